//--- hdl/ccd_pkg.sv
package ccd_pkg;

  // Register byte offsets
  localparam logic [7:0] CCD_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] CCD_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] CCD_OFS_STAT0 = 8'h08;
  localparam logic [7:0] CCD_OFS_STAT1 = 8'h0c;

  // Control word fields, counts stored minus one
  localparam int CCD_HIGH1_LSB    = 0;
  localparam int CCD_LOW1_LSB     = 4;
  localparam int CCD_HIGH2_LSB    = 8;
  localparam int CCD_LOW2_LSB     = 12;
  localparam int CCD_BYP1_BIT     = 16;
  localparam int CCD_BYP2_BIT     = 17;
  localparam int CCD_CORR_OFF_BIT = 18;
  localparam int CCD_SRC_RAW_BIT  = 19;
  localparam int CCD_CTRL_WIDTH   = 20;

  // Status word fields
  localparam int CCD_DIV_LSB      = 0;
  localparam int CCD_DIV_WIDTH    = 11;
  localparam int CCD_LVL_BIT      = 16;

  // Reset values: counts zero, stages active, correction on, prescaled source
  localparam logic [CCD_CTRL_WIDTH-1:0] CCD_CTRL_RST = 20'h00000;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int CCD_HTRANS_ACT_BIT = 1;

  localparam int CCD_NUM_CHAN = 2;

endpackage

//--- hdl/ccd_stage.sv
`timescale 1ns/100ps
module ccd_stage (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Stage input level, same clock domain
  input  wire logic       inLvl,
  // Configuration
  input  wire logic       bypass,
  input  wire logic       corrOff,
  input  wire logic [3:0] highCnt,
  input  wire logic [3:0] lowCnt,
  // Stage output level
  output logic            outLvl_q
);

  logic       inPrev_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       out_d;

  wire       rise     = inLvl & ~inPrev_q;
  wire       fall     = ~inLvl & inPrev_q;
  // Correction counts both input edges: D half periods per output phase
  wire [4:0] halfLim  = 5'(highCnt) + 5'(lowCnt) + 5'h01;
  wire [4:0] phaseLim = outLvl_q ? 5'(highCnt) : 5'(lowCnt);
  wire       corrStep = ~corrOff & (rise | fall);
  wire       rawStep  = corrOff & rise;
  wire       step     = corrStep | rawStep;
  wire [4:0] lim      = corrOff ? phaseLim : halfLim;
  wire       wrap     = step & (cnt_q == lim);

  always_comb begin
    out_d = outLvl_q;
    cnt_d = cnt_q;
    if (bypass) begin
      out_d = inLvl;
      cnt_d = 5'h00;
    end else if (wrap) begin
      out_d = ~outLvl_q;
      cnt_d = 5'h00;
    end else if (step) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inPrev_q <= 1'b0;
      cnt_q    <= 5'h00;
      outLvl_q <= 1'b1;
    end else begin
      inPrev_q <= inLvl;
      cnt_q    <= cnt_d;
      outLvl_q <= out_d;
    end
  end

endmodule

//--- hdl/ccd_channel_divider.sv
`timescale 1ns/100ps
module ccd_channel_divider (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Clock sources from pins
  input  wire logic        vcoDivClk,
  input  wire logic        rawClk,
  // Divided channel clocks to the output drivers
  output logic [1:0]       chanClk
);

  logic [1:0]  vcoSync_q;
  logic [1:0]  rawSync_q;
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic [31:0] hrdata_q;
  logic [1:0]  chanClk_q;
  logic [ccd_pkg::CCD_CTRL_WIDTH-1:0] ctrl_q [ccd_pkg::CCD_NUM_CHAN];
  logic [31:0] statWord [ccd_pkg::CCD_NUM_CHAN];
  logic [1:0]  stageOut [ccd_pkg::CCD_NUM_CHAN];

  // Pins are asynchronous to core_clk; only the second flop is read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vcoSync_q <= 2'h0;
      rawSync_q <= 2'h0;
    end else begin
      vcoSync_q <= {vcoSync_q[0], vcoDivClk};
      rawSync_q <= {rawSync_q[0], rawClk};
    end
  end

  // Bus decode; zero wait states, every transfer answered OKAY
  wire        addrPhase = hsel & hready & htrans[ccd_pkg::CCD_HTRANS_ACT_BIT];
  wire        wrTake    = addrPhase & hwrite;
  wire        rdTake    = addrPhase & ~hwrite;
  wire [7:0]  rdAddr    = haddr[7:0];
  wire        hitCtrl0  = wrAddr_q == ccd_pkg::CCD_OFS_CTRL0;
  wire        hitCtrl1  = wrAddr_q == ccd_pkg::CCD_OFS_CTRL1;
  wire        wrCtrl0   = wrPend_q & hitCtrl0;
  wire        wrCtrl1   = wrPend_q & hitCtrl1;
  // Forward a pending write so a read right behind it sees new data
  wire [31:0] ctrl0Now  = wrCtrl0 ? hwdata : 32'(ctrl_q[0]);
  wire [31:0] ctrl1Now  = wrCtrl1 ? hwdata : 32'(ctrl_q[1]);
  wire [31:0] ctrl0Rd   = {12'h000, ctrl0Now[ccd_pkg::CCD_CTRL_WIDTH-1:0]};
  wire [31:0] ctrl1Rd   = {12'h000, ctrl1Now[ccd_pkg::CCD_CTRL_WIDTH-1:0]};
  wire [31:0] rdMux     = (rdAddr == ccd_pkg::CCD_OFS_CTRL0) ? ctrl0Rd :
                          (rdAddr == ccd_pkg::CCD_OFS_CTRL1) ? ctrl1Rd :
                          (rdAddr == ccd_pkg::CCD_OFS_STAT0) ? statWord[0] :
                          (rdAddr == ccd_pkg::CCD_OFS_STAT1) ? statWord[1] :
                          32'h00000000;

  // Write address phase held for its data phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= wrTake;
      wrAddr_q <= haddr[7:0];
    end
  end

  // Never stalls and never errors, so every answer comes in the next cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= 32'h00000000;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (rdTake) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // Correction starts enabled: disable bit resets to zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q[0] <= ccd_pkg::CCD_CTRL_RST;
      ctrl_q[1] <= ccd_pkg::CCD_CTRL_RST;
    end else begin
      if (wrCtrl0) begin
        ctrl_q[0] <= hwdata[ccd_pkg::CCD_CTRL_WIDTH-1:0];
      end
      if (wrCtrl1) begin
        ctrl_q[1] <= hwdata[ccd_pkg::CCD_CTRL_WIDTH-1:0];
      end
    end
  end

  // Configuration is not checked; bad settings just give odd duty cycles
  genvar ch;
  generate
    for (ch = 0; ch < ccd_pkg::CCD_NUM_CHAN; ch++) begin : gChan
      wire [3:0]  high1   = ctrl_q[ch][ccd_pkg::CCD_HIGH1_LSB +: 4];
      wire [3:0]  low1    = ctrl_q[ch][ccd_pkg::CCD_LOW1_LSB +: 4];
      wire [3:0]  high2   = ctrl_q[ch][ccd_pkg::CCD_HIGH2_LSB +: 4];
      wire [3:0]  low2    = ctrl_q[ch][ccd_pkg::CCD_LOW2_LSB +: 4];
      wire        byp1    = ctrl_q[ch][ccd_pkg::CCD_BYP1_BIT];
      wire        byp2    = ctrl_q[ch][ccd_pkg::CCD_BYP2_BIT];
      wire        corrOff = ctrl_q[ch][ccd_pkg::CCD_CORR_OFF_BIT];
      wire        srcRaw  = ctrl_q[ch][ccd_pkg::CCD_SRC_RAW_BIT];
      // Source select; both stages bypassed passes the source duty
      wire        srcLvl  = srcRaw ? rawSync_q[1] : vcoSync_q[1];
      // Bypassed stage counts as divide by one
      wire [5:0]  div1    = byp1 ? 6'h01 : 6'(high1) + 6'(low1) + 6'h02;
      wire [5:0]  div2    = byp2 ? 6'h01 : 6'(high2) + 6'(low2) + 6'h02;
      wire [11:0] divProd = div1 * div2;

      assign statWord[ch] = {15'h0000, chanClk_q[ch], 5'h00,
                             divProd[ccd_pkg::CCD_DIV_WIDTH-1:0]};

      // First stage feeds second; last active stage sets the duty
      ccd_stage uStage1 (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .inLvl      (srcLvl),
        .bypass     (byp1),
        .corrOff    (corrOff),
        .highCnt    (high1),
        .lowCnt     (low1),
        .outLvl_q   (stageOut[ch][0])
      );
      ccd_stage uStage2 (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .inLvl      (stageOut[ch][0]),
        .bypass     (byp2),
        .corrOff    (corrOff),
        .highCnt    (high2),
        .lowCnt     (low2),
        .outLvl_q   (stageOut[ch][1])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chanClk_q <= 2'h0;
    end else begin
      chanClk_q <= {stageOut[1][1], stageOut[0][1]};
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign chanClk   = chanClk_q;

endmodule

//--- verification/ccd_chk.sv
`timescale 1ns/100ps
module ccd_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Clocks
  input wire logic        vcoDivClk,
  input wire logic        rawClk,
  input wire logic [1:0]  chanClk
);
  logic [19:0] ctl_q [2];
  logic [1:0]  wr_q;
  logic [3:0]  quiet_q;
  wire         rd = hsel & hready & htrans[1] & !hwrite;
  wire  [1:0]  byp = {&ctl_q[1][17:16], &ctl_q[0][17:16]};
  wire  [1:0]  src = {ctl_q[1][19] ? rawClk : vcoDivClk, ctl_q[0][19] ? rawClk : vcoDivClk};
  function automatic logic [10:0] dv(logic [19:0] c);
    dv = (c[16] ? 11'h1 : 11'(c[3:0]) + 11'(c[7:4]) + 11'h2)
       * (c[17] ? 11'h1 : 11'(c[11:8]) + 11'(c[15:12]) + 11'h2);
  endfunction
  // Quiet count restarts on config writes, which may move the output at once
  always_ff @(posedge core_clk) begin
    wr_q <= {2{hsel & hready & htrans[1] & hwrite}} & {haddr[7:0] == 8'h04, haddr[7:0] == 8'h00};
    quiet_q <= (!rst_n || wr_q != 2'h0) ? 4'h0 : quiet_q + 4'(quiet_q != 4'hf);
    for (int i = 0; i < 2; i++)
      ctl_q[i] <= !rst_n ? 20'h0 : wr_q[i] ? hwdata[19:0] : ctl_q[i];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_up: assert property (rst_n |=> hreadyout)
    else $error("bus not ready");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_unmapped_zero: assert property (rd && haddr[7:0] > 8'h0c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_back: assert property (rd && haddr[7:3] == 5'h0 |=>
    hrdata == {12'h0, ctl_q[$past(haddr[2])]}) else $error("control readback");
  a_stat_div: assert property (rd && haddr[7:3] == 5'h1 |=>
    hrdata[10:0] == dv(ctl_q[$past(haddr[2])])) else $error("total divide");
  a_stat_level: assert property (rd && haddr[7:3] == 5'h1 |=>
    hrdata[16] == ($past(haddr[2]) ? $past(chanClk[1]) : $past(chanClk[0])))
    else $error("status level");
  // Pin to output takes five cycles: two sync flops, two stages, output flop
  a_chan_quiet: assert property (quiet_q > 4'h7 |->
    ((chanClk ^ $past(chanClk)) & ~($past(src, 5) ^ $past(src, 6))) == 2'h0)
    else $error("output moved without source edge");
  a_bypass_pass0: assert property (byp[0] && quiet_q > 4'h7 |->
    chanClk[0] == $past(src[0], 5)) else $error("bypass channel 0");
  a_bypass_pass1: assert property (byp[1] && quiet_q > 4'h7 |->
    chanClk[1] == $past(src[1], 5)) else $error("bypass channel 1");
  cover property (wr_q[1]);
  cover property (byp[0] && quiet_q > 4'h7);
  cover property (rd && haddr[7:0] == 8'h08);
endmodule
bind ccd_channel_divider ccd_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vcoDivClk(vcoDivClk),
  .rawClk(rawClk), .chanClk(chanClk));

//--- verification/ccd_src_model.sv
`timescale 1ns/100ps
module ccd_src_model (
  input wire logic core_clk,
  output logic     vcoDivClk,
  output logic     rawClk
);
  logic [4:0] cnt_q = 5'h0;
  // Prescaled source at 50%, raw source skewed to 3 of 8 to expose passthrough
  always @(posedge core_clk) cnt_q <= (cnt_q == 5'h17) ? 5'h0 : cnt_q + 5'h1;
  assign vcoDivClk = (cnt_q % 5'h6) < 5'h3;
  assign rawClk    = (cnt_q % 5'h8) < 5'h3;
endmodule

//--- verification/cascaded_channel_divider_duty_bench.sv
`timescale 1ns/100ps
module cascaded_channel_divider_duty_bench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         vco;
  wire         raw;
  wire  [1:0]  chanClk;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          seed = 70791;
  int          cyc = 0;
  ccd_channel_divider DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .vcoDivClk(vco), .rawClk(raw),
    .chanClk(chanClk));
  ccd_src_model u_src (.core_clk(core_clk), .vcoDivClk(vco), .rawClk(raw));
  initial forever #50 core_clk = ~core_clk;
  task complete_run;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task bus(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wlvl(int ch, logic v);
    for (int k = 0; k < 3000 && chanClk[ch] !== v; k++) @(posedge core_clk);
  endtask
  // Skipped up to the second rising edge: counters are not restarted on reconfiguration
  task period(int ch, output logic [31:0] hl);
    repeat (2) begin
      wlvl(ch, 1'b0);
      wlvl(ch, 1'b1);
    end
    hl = 32'h0;
    while (chanClk[ch] === 1'b1) begin @(posedge core_clk); hl += 32'h10000; end
    while (chanClk[ch] === 1'b0) begin @(posedge core_clk); hl += 32'h1; end
  endtask
  // Model sources: prescaled period 6, raw period 8, both high for 3 cycles
  function automatic logic [31:0] expHiLo(logic [19:0] c);
    int p;
    int d1;
    int d2;
    int hi1;
    int hi;
    p = c[19] ? 8 : 6;
    d1 = c[16] ? 1 : c[3:0] + c[7:4] + 2;
    d2 = c[17] ? 1 : c[11:8] + c[15:12] + 2;
    hi1 = (d1 % 2 == 0) ? d1 / 2 * p : (d1 - 1) / 2 * p + 3;
    if (c[18]) hi1 = c[16] ? 3 : (c[3:0] + 1) * p;
    hi = (d2 % 2 == 0) ? d2 / 2 * d1 * p : (d2 - 1) / 2 * d1 * p + hi1;
    if (c[18] && !c[17]) hi = (c[11:8] + 1) * d1 * p;
    return {16'(hi), 16'(d1 * d2 * p - hi)};
  endfunction
  initial begin
    logic [31:0] r;
    logic [31:0] c;
    logic [31:0] n;
    int ch;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, 8'h08, 32'h0, r);
    chk({21'h0, r[10:0]}, 32'h4);
    period(0, r);
    chk(r, expHiLo(20'h0));
    bus(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b1, 8'h00, 32'hf0000, r);
    period(0, r);
    chk(r, expHiLo(20'hf0000));
    bus(1'b1, 8'h00, 32'ha0000, r);
    period(0, r);
    chk(r, expHiLo(20'ha0000));
    bus(1'b1, 8'h04, 32'he0021, r);
    period(1, r);
    chk(r, expHiLo(20'he0021));
    repeat (14) begin
      ch = $unsigned($random(seed)) % 2;
      n = $random(seed);
      c = $random(seed) & 32'h0006_3333;
      c[16] = c[17] & n[0];
      c[7:4] = c[3:0] + 4'(n[1]);
      c[15:12] = c[11:8] + 4'(n[2] & n[1]);
      bus(1'b1, 8'(ch * 4), c, r);
      period(ch, r);
      chk(r, expHiLo(c[19:0]));
    end
    bus(1'b1, 8'h04, 32'h4f0f0, r);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 8'h04, 32'h0, r);
    chk(r, 32'h0);
    period(1, r);
    chk(r, expHiLo(20'h0));
    complete_run();
  end
endmodule
